/* File: hw/qsl_params.svh */
// Offsets, field positions, reset values and limits of the queue monitor
`ifndef QSL_PARAMS_SVH
`define QSL_PARAMS_SVH

// Register byte offsets on the APB
`define QSL_OFF_STARVE_0_3 12'h000
`define QSL_OFF_STARVE_4_7 12'h004
`define QSL_OFF_STARVE_8_11 12'h008
`define QSL_OFF_STARVE_12_15 12'h00c
`define QSL_OFF_LINK_AREA_FIRST_BASE 12'h010
`define QSL_OFF_LINK_AREA_FIRST_ENTRIES 12'h014
`define QSL_OFF_IRQ_STATUS 12'h018
`define QSL_OFF_IRQ_MASK 12'h01c

// Field layout
`define QSL_CNT_W 8
`define QSL_CNT_MAX 8'hff
`define QSL_SIZE_W 14
`define QSL_SHIFT 2
`define QSL_ADDR_W 12
`define QSL_IDX_W 16
`define QSL_NUM_QUEUES 16
`define QSL_QUEUES_PER_REG 4
`define QSL_MAX_REGS 4

// Reset values
`define QSL_RST_COUNT 8'h00
`define QSL_RST_BASE 32'h0000_0000
`define QSL_RST_SIZE 14'h0000
`define QSL_RST_DATA 32'h0000_0000

`endif

/* File: hw/qsl_pkg.sv */
// Types shared by the queue monitor files
package qsl_pkg;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} qsl_apb_req_t;

	// Link address lookup request
	typedef struct packed {
		logic valid;
		logic [15:0] index;
	} qsl_link_req_t;

	// Link address lookup answer
	typedef struct packed {
		logic valid;
		logic region;
		logic [31:0] addr;
	} qsl_link_rsp_t;

	// APB slave phase, one-hot
	typedef enum logic [1:0] {
		QSL_ST_IDLE = 2'b01,
		QSL_ST_ACCESS = 2'b10
	} qsl_state_t;
endpackage : qsl_pkg

/* File: hw/qsl_starve_counter.sv */
// One saturating, clear-on-read starvation counter
`timescale 1ns/1ps
`include "qsl_params.svh"

module qsl_starve_counter (
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic inc, // Queue read while empty
	input wire logic clr, // Clearing read of the owning register
	output logic [7:0] count, // Current count
	output logic reached_max // Pulse when the count reaches its top
);
	logic [7:0] next_count;
	logic at_max;

	// Saturate at the top; an increment during a clear survives
	assign at_max = (count == `QSL_CNT_MAX);
	assign next_count = clr ? (inc ? 8'h01 : `QSL_RST_COUNT)
		: ((inc && !at_max) ? count + 8'h01 : count);

	// Count register
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			count <= `QSL_RST_COUNT;
			reached_max <= 1'b0;
		end else begin
			count <= next_count;
			reached_max <= inc && !clr && (count == `QSL_CNT_MAX - 8'h01);
		end
	end
endmodule : qsl_starve_counter

/* File: hw/qsl_queue_monitor.sv */
// Free queue starvation counters, linking RAM region 0 settings and link address lookup
`timescale 1ns/1ps
`include "qsl_params.svh"

module qsl_queue_monitor
	import qsl_pkg::*;
#(
	parameter int NUM_QUEUES = `QSL_NUM_QUEUES, // Free queues watched
	parameter int IDX_W = `QSL_IDX_W // Used width of a descriptor index
) (
	input wire logic clk_sys, // System clock, 40 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire qsl_apb_req_t apb_req, // APB request signals
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic [NUM_QUEUES-1:0] queue_read, // Free queue read strobes
	input wire logic [NUM_QUEUES-1:0] queue_empty, // Free queue empty levels
	input wire qsl_link_req_t link_req, // Lookup of a descriptor index
	input wire logic [31:0] link_area_second_base, // Region 1 base from outside
	output qsl_link_rsp_t link_rsp, // Linking location answer
	output logic irq // Level interrupt
);
	localparam int NUM_REGS = NUM_QUEUES / `QSL_QUEUES_PER_REG;

	// Elaboration check on the queue count and index width
	if ((NUM_QUEUES % `QSL_QUEUES_PER_REG) != 0 || NUM_QUEUES < 4 || NUM_QUEUES > 16) begin : g_bad_queues
		$error("NUM_QUEUES must be 4, 8, 12 or 16");
	end
	if (IDX_W < `QSL_SIZE_W || IDX_W > 16) begin : g_bad_idx
		$error("IDX_W must lie between 14 and 16");
	end

	// Address match against a register offset
	function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
		addr_is = (addr == off);
	endfunction : addr_is

	// Linking location from a base and an index
	function automatic logic [31:0] link_addr(input logic [31:0] base, input logic [15:0] index);
		link_addr = base + {14'h0000, index, 2'b00};
	endfunction : link_addr

	// Index of the counter register addressed, or none
	function automatic logic [2:0] count_reg(input logic [11:0] addr);
		if (addr_is(addr, `QSL_OFF_STARVE_0_3)) begin
			count_reg = 3'd0;
		end else if (addr_is(addr, `QSL_OFF_STARVE_4_7)) begin
			count_reg = 3'd1;
		end else if (addr_is(addr, `QSL_OFF_STARVE_8_11)) begin
			count_reg = 3'd2;
		end else if (addr_is(addr, `QSL_OFF_STARVE_12_15)) begin
			count_reg = 3'd3;
		end else begin
			count_reg = 3'd7;
		end
	endfunction : count_reg

	qsl_state_t state;
	qsl_state_t next_state;
	logic [31:0] link_area_first_base;
	logic [13:0] link_area_first_entries;
	logic [NUM_QUEUES-1:0] irq_status;
	logic [NUM_QUEUES-1:0] irq_mask;
	logic [NUM_QUEUES*8-1:0] count_flat;
	logic [127:0] count_all;
	logic [NUM_QUEUES-1:0] starve_event;
	logic [NUM_QUEUES-1:0] sat_event;
	logic [NUM_QUEUES-1:0] count_clr;
	logic err_q;
	logic [31:0] next_prdata;
	logic next_err;

	// Bus phase decode
	wire setup_phase = apb_req.psel && !apb_req.penable && (state == QSL_ST_IDLE);
	wire access_phase = apb_req.psel && apb_req.penable && (state == QSL_ST_ACCESS);
	wire [2:0] sel_count = count_reg(apb_req.paddr);
	wire hit_count = (sel_count < NUM_REGS[2:0]);
	wire hit_base = addr_is(apb_req.paddr, `QSL_OFF_LINK_AREA_FIRST_BASE);
	wire hit_size = addr_is(apb_req.paddr, `QSL_OFF_LINK_AREA_FIRST_ENTRIES);
	wire hit_status = addr_is(apb_req.paddr, `QSL_OFF_IRQ_STATUS);
	wire hit_mask = addr_is(apb_req.paddr, `QSL_OFF_IRQ_MASK);
	wire mapped = hit_count || hit_base || hit_size || hit_status || hit_mask;

	// Clearing read is taken in the setup cycle, with the data capture
	wire read_clear = setup_phase && !apb_req.pwrite && hit_count;

	// Writes take effect on the completing edge
	wire wr_ok = access_phase && apb_req.pwrite && !err_q;
	wire wr_base = wr_ok && hit_base;
	wire wr_size = wr_ok && hit_size;
	wire wr_status = wr_ok && hit_status;
	wire wr_mask = wr_ok && hit_mask;

	// Empty reads of each free queue
	assign starve_event = queue_read & queue_empty;

	// Clear the four counters of the register being read
	always_comb begin
		for (int q = 0; q < NUM_QUEUES; q++) begin
			count_clr[q] = read_clear && (sel_count == 3'(q / `QSL_QUEUES_PER_REG));
		end
	end

	// One counter per queue, packed one byte each, queue 0 lowest
	for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_count
		qsl_starve_counter u_count (
			.clk_sys(clk_sys),
			.resetn(resetn),
			.inc(starve_event[q]),
			.clr(count_clr[q]),
			.count(count_flat[q*8 +: 8]),
			.reached_max(sat_event[q])
		);
	end

	// Counter registers beyond the queue count read as zero
	assign count_all = 128'(count_flat);

	// Read data selection
	always_comb begin
		next_prdata = `QSL_RST_DATA;
		if (hit_count) begin
			next_prdata = count_all[sel_count[1:0]*32 +: 32];
		end else if (hit_base) begin
			next_prdata = link_area_first_base;
		end else if (hit_size) begin
			next_prdata = {18'h00000, link_area_first_entries};
		end else if (hit_status) begin
			next_prdata = 32'(irq_status);
		end else if (hit_mask) begin
			next_prdata = 32'(irq_mask);
		end
	end

	assign next_err = !mapped;

	// Phase sequencing
	always_comb begin
		case (state)
			QSL_ST_IDLE: begin
				next_state = setup_phase ? QSL_ST_ACCESS : QSL_ST_IDLE;
			end
			QSL_ST_ACCESS: begin
				next_state = QSL_ST_IDLE;
			end
			default: begin
				next_state = QSL_ST_IDLE;
			end
		endcase
	end

	// Bus state and captured answer
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= QSL_ST_IDLE;
			prdata <= `QSL_RST_DATA;
			err_q <= 1'b0;
		end else begin
			state <= next_state;
			if (setup_phase) begin
				prdata <= apb_req.pwrite ? `QSL_RST_DATA : next_prdata;
				err_q <= next_err;
			end
		end
	end

	// Answer in the access cycle, no wait states
	assign pready = (state == QSL_ST_ACCESS);
	assign pslverr = pready && err_q;

	// Linking RAM region 0 settings
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			link_area_first_base <= `QSL_RST_BASE;
			link_area_first_entries <= `QSL_RST_SIZE;
		end else begin
			if (wr_base) begin
				link_area_first_base <= apb_req.pwdata;
			end
			if (wr_size) begin
				link_area_first_entries <= apb_req.pwdata[13:0];
			end
		end
	end

	// Interrupt status, set wins over write-one-to-clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irq_status <= '0;
			irq_mask <= '0;
		end else begin
			irq_status <= (irq_status & ~(wr_status ? apb_req.pwdata[NUM_QUEUES-1:0] : '0)) | sat_event;
			if (wr_mask) begin
				irq_mask <= apb_req.pwdata[NUM_QUEUES-1:0];
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Region choice for a looked-up index
	wire [15:0] req_index = 16'(link_req.index[IDX_W-1:0]);
	wire in_first = (req_index < {2'b00, link_area_first_entries});
	wire [31:0] sel_base = in_first ? link_area_first_base : link_area_second_base;

	// Lookup answer one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			link_rsp <= '0;
		end else begin
			link_rsp.valid <= link_req.valid;
			if (link_req.valid) begin
				link_rsp.region <= !in_first;
				link_rsp.addr <= link_addr(sel_base, req_index);
			end
		end
	end
endmodule : qsl_queue_monitor

/* File: testbench/qsl_queue_monitor_props.sv */
// Port checker of the queue monitor
`timescale 1ns/1ps
module qsl_queue_monitor_props
	import qsl_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic resetn, // Reset, active low
	input wire qsl_apb_req_t apb_req, // APB request
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire qsl_link_req_t link_req, // Lookup request
	input wire logic [31:0] link_area_second_base, // Region 1 base
	input wire qsl_link_rsp_t link_rsp, // Lookup answer
	input wire logic irq // Interrupt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Setup phase of a transfer
	wire setup = apb_req.psel && !apb_req.penable;
	// Lookup request and answer
	sequence s_req;
		link_req.valid;
	endsequence
	sequence s_rsp;
		link_rsp.valid;
	endsequence
	a_rsp_follows: assert property (s_req |=> s_rsp) else $error("lookup answer missing");
	a_rsp_cause: assert property (s_rsp |-> $past(link_req.valid)) else $error("stray lookup answer");
	a_region1_addr: assert property (s_rsp and link_rsp.region |->
		link_rsp.addr == $past(link_area_second_base) + {$past(link_req.index), 2'b00})
		else $error("region 1 address wrong");
	a_rsp_hold: assert property (!link_req.valid |=> $stable(link_rsp.addr) && $stable(link_rsp.region))
		else $error("lookup answer moved");
	a_apb_ready: assert property (setup |=> pready) else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
	a_err_data: assert property (pready && pslverr && !apb_req.pwrite |-> prdata == 32'h0)
		else $error("error read not zero");
	a_data_hold: assert property (!setup |=> $stable(prdata)) else $error("read data moved");
	a_reset_quiet: assert property ($rose(resetn) |-> !pready && !irq && prdata == 32'h0)
		else $error("outputs not clear after reset");
endmodule : qsl_queue_monitor_props

bind qsl_queue_monitor qsl_queue_monitor_props u_props (.clk_sys, .resetn, .apb_req, .prdata, .pready,
	.pslverr, .link_req, .link_area_second_base, .link_rsp, .irq);

/* File: testbench/qsl_dma_model.sv */
// Behavioural DMA channels reading the free queues
`timescale 1ns/1ps
module qsl_dma_model (
	input wire logic clk_sys, // Clock
	input wire logic [15:0] rd_q, // Queues to read
	input wire logic [15:0] emp_q, // Empty state with a read
	output logic [15:0] queue_read, // Read strobes
	output logic [15:0] queue_empty // Empty levels
);
	initial queue_read = '0;
	initial queue_empty = '0;
	// Unread queues show a changing empty level
	always @(posedge clk_sys) begin
		queue_read <= rd_q;
		queue_empty <= (rd_q & emp_q) | (~rd_q & ~queue_empty);
	end
endmodule : qsl_dma_model

/* File: testbench/qsl_queue_monitor_tb.sv */
// Self-checking bench of the queue monitor
`timescale 1ns/1ps
`include "qsl_params.svh"
module qsl_queue_monitor_tb
	import qsl_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	qsl_apb_req_t apb_req = '0;
	qsl_link_req_t link_req = '0;
	logic [31:0] prdata, rd, snap, base2 = '0, seed = 32'd54451;
	logic pready, pslverr, irq, e;
	logic [15:0] queue_read, queue_empty, rd_q = '0, emp_q = '0;
	logic [1:0] mode = '0;
	qsl_link_rsp_t link_rsp;
	int failures = 0, num_checks = 0, cnt[16];
	initial forever #12.5 clk_sys = ~clk_sys;
	qsl_queue_monitor u_dut (.clk_sys, .resetn, .apb_req, .prdata, .pready, .pslverr, .queue_read,
		.queue_empty, .link_req, .link_area_second_base(base2), .link_rsp, .irq);
	qsl_dma_model u_dma (.clk_sys, .rd_q, .emp_q, .queue_read, .queue_empty);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic complete_run();
		$display("Checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Full-word APB transfer, waits for ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		bit ok;
		ok = 0;
		@(posedge clk_sys);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		// Request stands until the edge at which pready is sampled high
		for (int i = 0; i < 16 && !ok; i++) begin
			@(posedge clk_sys);
			ok = pready === 1'b1;
			rd = prdata;
			e = pslverr;
		end
		apb_req <= '0;
		if (!ok) begin
			failures++;
			$display("Error at %0t: no ready on the bus", $time);
			complete_run();
		end
	endtask : apb
	// Queue traffic: random, or queue 5 read empty
	always @(posedge clk_sys) begin
		rd_q <= mode == 2'd1 ? 16'(rnd()) : {10'h0, mode == 2'd2, 5'h0};
		emp_q <= mode == 2'd1 ? 16'(rnd()) : 16'hffff;
	end
	// Reference counts; a counter read snaps and clears first
	always @(posedge clk_sys) begin
		if (!resetn) for (int q = 0; q < 16; q++) cnt[q] = 0;
		else begin
			if (apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr < 12'h010)
				for (int q = 0; q < 4; q++) begin
					snap[q*8 +: 8] = cnt[apb_req.paddr[3:2]*4+q][7:0];
					cnt[apb_req.paddr[3:2]*4+q] = 0;
				end
			for (int q = 0; q < 16; q++) if (queue_read[q] && queue_empty[q] && cnt[q] < 255) cnt[q]++;
		end
	end
	initial begin
		logic [31:0] b, s;
		logic [15:0] ix;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		// Reset values, then an unmapped place
		for (int r = 0; r < 8; r++) begin
			apb(0, 12'(r * 4), 0);
			chk(rd, 0);
		end
		apb(0, 12'h020, 0);
		chk(e, 1);
		chk(rd, 0);
		// Counts under traffic, reads clearing meanwhile
		mode <= 2'd1;
		repeat (30) @(posedge clk_sys);
		for (int r = 0; r < 8; r++) begin
			apb(0, 12'(r % 4 * 4), 0);
			chk(rd, snap);
		end
		// Saturate queue 5, masked then unmasked interrupt
		mode <= 2'd2;
		repeat (300) @(posedge clk_sys);
		mode <= 2'd0;
		apb(0, `QSL_OFF_IRQ_STATUS, 0);
		chk(rd, 32'h20);
		chk(irq, 0);
		apb(1, `QSL_OFF_IRQ_MASK, 32'h20);
		apb(0, `QSL_OFF_STARVE_4_7, 0);
		chk(rd, snap);
		chk(rd[15:8], 8'hff);
		chk(irq, 1);
		apb(1, `QSL_OFF_IRQ_STATUS, 32'h20);
		apb(0, `QSL_OFF_IRQ_STATUS, 0);
		chk(rd, 0);
		chk(irq, 0);
		// Region 0 settings and lookups, boundary first
		for (int k = 0; k < 12; k++) begin
			b = rnd() & 32'hffff_fffc;
			s = rnd();
			ix = k == 0 ? {2'b0, s[13:0]} : {2'b0, 14'(rnd())};
			apb(1, `QSL_OFF_LINK_AREA_FIRST_BASE, b);
			apb(1, `QSL_OFF_LINK_AREA_FIRST_ENTRIES, s);
			apb(0, `QSL_OFF_LINK_AREA_FIRST_BASE, 0);
			chk(rd, b);
			apb(0, `QSL_OFF_LINK_AREA_FIRST_ENTRIES, 0);
			chk(rd, {18'h0, s[13:0]});
			base2 <= rnd();
			@(posedge clk_sys);
			link_req <= '{1'b1, ix};
			@(posedge clk_sys);
			link_req <= '0;
			@(negedge clk_sys);
			chk({link_rsp.valid, link_rsp.region}, {1'b1, ix >= s[13:0]});
			chk(link_rsp.addr, (ix >= s[13:0] ? base2 : b) + {ix, 2'b00});
		end
		complete_run();
	end
endmodule : qsl_queue_monitor_tb
